// ### common/cfg_load_if.sv
// Write path from the EEPROM loader into the configuration bank.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface cfg_load_if;
  logic       we;
  logic [4:0] idx;
  logic [7:0] data;
  logic       go;
  logic       busy;
  logic       done;
  logic       err;

  modport loader (output we, idx, data, busy, done, err, input go);
  modport bank   (input we, idx, data, busy, done, err, output go);
endinterface
`default_nettype wire

// ### common/rptr_pkg.sv
// Constants and types for the repeater channel configuration bank.
// Assumes an 8-bit register port and a same-clock EEPROM byte reader.
package rptr_pkg;
  localparam int NUM_CH       = 8;
  localparam int REGS_PER_CH  = 4;
  localparam int NUM_CFG      = 32;

  // Register offsets
  localparam logic [7:0] ADDR_CFG_LAST = 8'h1F;
  localparam logic [7:0] ADDR_SLV_ADDR = 8'h20;
  localparam logic [7:0] ADDR_STATUS   = 8'h21;
  localparam logic [7:0] ADDR_PTR      = 8'h22;
  localparam logic [7:0] ADDR_DATA     = 8'h23;

  // Per-channel register slots
  localparam int SLOT_CTRL  = 0;
  localparam int SLOT_BOOST = 1;
  localparam int SLOT_GAIN  = 2;
  localparam int SLOT_TAPS  = 3;

  // Field positions
  localparam int SD_OVR_LSB  = 0;
  localparam int BYPASS_BIT  = 2;
  localparam int GAIN_HI_BIT = 3;
  localparam int BW_LSB      = 4;
  localparam int LIMIT_BIT   = 6;
  localparam int BOOST1_LSB  = 0;
  localparam int BOOST2_LSB  = 3;
  localparam int DC_GAIN_LSB = 0;
  localparam int MAIN_LSB    = 4;
  localparam int PRE_LSB     = 0;
  localparam int POST_LSB    = 3;

  // Reset values
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] PTR_RESET  = 8'h00;

  // Signal-detect override codes; 2'h3 behaves as automatic
  localparam logic [1:0] SD_AUTO      = 2'h0;
  localparam logic [1:0] SD_FORCE_ON  = 2'h1;
  localparam logic [1:0] SD_FORCE_OFF = 2'h2;

  localparam logic [6:0] SLV_ADDR_BASE = 7'h18;
  localparam logic [7:0] EE_DEV_ADDR   = 8'hA0;
  localparam logic [4:0] EE_LAST_BYTE  = 5'h1F;
  localparam logic [1:0] STRAP_SETTLE  = 2'h3;

  typedef struct packed {
    logic [2:0] boost1;
    logic [2:0] boost2;
    logic       bypass;
    logic [1:0] bw;
    logic       gain_hi;
    logic [2:0] dc_gain;
    logic       limit_en;
    logic [2:0] pre;
    logic [2:0] main;
    logic [2:0] post;
    logic       path_en;
  } ch_cfg_type;

  typedef enum logic [3:0] {
    LD_IDLE = 4'h1,
    LD_REQ  = 4'h2,
    LD_WAIT = 4'h4,
    LD_DONE = 4'h8
  } load_state_type;
endpackage

// ### design/ee_loader.sv
// EEPROM self-load sequencer: fetches the configuration bytes in order.
// Assumes a same-clock byte reader that answers each request once.
`timescale 1ns/1ps
`default_nettype none
module ee_loader (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  cfg_load_if.loader      lw,
  output logic [7:0]      ee_dev_addr,
  output logic            ee_rd_req,
  output logic [9:0]      ee_byte_addr,
  input  wire logic       ee_rd_valid,
  input  wire logic [7:0] ee_rd_data,
  input  wire logic       ee_rd_err
);
  typedef struct packed {
    rptr_pkg::load_state_type st;
    logic [4:0]               cnt;
    logic                     req;
    logic                     we;
    logic [7:0]               data;
    logic                     done;
    logic                     err;
  } load_type;

  load_type q;
  load_type d;

  always_comb begin
    d      = q;
    d.req  = 1'b0;
    d.we   = 1'b0;
    d.done = 1'b0;
    d.err  = 1'b0;
    // Index of the byte just written trails the counter by one write
    if (q.we) d.cnt = q.cnt + 5'h01;
    case (q.st)
      rptr_pkg::LD_IDLE: begin
        if (lw.go) begin
          d.cnt = 5'h00;
          d.st  = rptr_pkg::LD_REQ;
        end
      end
      rptr_pkg::LD_REQ: begin
        d.req = 1'b1;
        d.st  = rptr_pkg::LD_WAIT;
      end
      rptr_pkg::LD_WAIT: begin
        if (ee_rd_err) begin
          // A failed load stops here; the done pin stays released
          d.err = 1'b1;
          d.st  = rptr_pkg::LD_DONE;
        end else if (ee_rd_valid) begin
          d.we   = 1'b1;
          d.data = ee_rd_data;
          if (q.cnt == rptr_pkg::EE_LAST_BYTE) begin
            d.done = 1'b1;
            d.st   = rptr_pkg::LD_DONE;
          end else begin
            d.st = rptr_pkg::LD_REQ;
          end
        end
      end
      rptr_pkg::LD_DONE: d.st = rptr_pkg::LD_DONE;
      default: d.st = rptr_pkg::LD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q    <= '0;
      q.st <= rptr_pkg::LD_IDLE;
    end else begin
      q <= d;
    end
  end

  assign lw.we        = q.we;
  assign lw.idx       = q.cnt;
  assign lw.data      = q.data;
  assign lw.done      = q.done;
  assign lw.err       = q.err;
  assign lw.busy      = (q.st == rptr_pkg::LD_REQ) || (q.st == rptr_pkg::LD_WAIT);
  assign ee_dev_addr  = rptr_pkg::EE_DEV_ADDR;
  assign ee_rd_req    = q.req;
  assign ee_byte_addr = {5'h00, q.cnt};
endmodule
`default_nettype wire

// ### design/repeater_cfg.sv
// Eight-channel repeater configuration bank with strap and load control.
// Assumes pads deliver four-level straps as 2-bit codes and that
// mgmt_mode_select reads 1 when pulled to supply, 0 when floating.
// Behaviour
// - Eight channels hold independent settings
// - Signal detect powers path on or off
// - Automatic detect after reset; software may override
// - Two stages with 3-bit boost codes
// - Stage-one bypass per channel
// - 2-bit bandwidth code per channel
// - High or low wideband gain select
// - 3-bit driver DC gain field
// - Limiting mode enables three-tap filter settings
// - Sample address straps once after reset
// - Each strap decodes to four levels
// - Address is 0x18 plus 4*upper plus lower
// - Mode pin pulled high selects slave only
// - Slave mode: trigger low resets registers
// - Slave mode: done pin follows trigger low
// - Slave port plus EEPROM master self-load
// - Master waits trigger low, reads EEPROM 0xA0
// - After load drive done low, revert slave
// - Data window writes auto-increment register pointer; reads leave it
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module repeater_cfg (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  input  wire logic [7:0]              sig_detect,
  input  wire logic [1:0]              strap_hi_lvl,
  input  wire logic [1:0]              strap_lo_lvl,
  input  wire logic                    mgmt_mode_select,
  input  wire logic                    load_trigger_n,
  output logic                         load_done_n_o,
  output logic                         load_done_n_oe_n,
  output rptr_pkg::ch_cfg_type [7:0]   ch_cfg,
  output logic [6:0]                   slave_addr,
  output logic [7:0]                   ee_dev_addr,
  output logic                         ee_rd_req,
  output logic [9:0]                   ee_byte_addr,
  input  wire logic                    ee_rd_valid,
  input  wire logic [7:0]              ee_rd_data,
  input  wire logic                    ee_rd_err
);
  typedef struct packed {
    logic [7:0]                 sd_m;
    logic [7:0]                 sd_s;
    logic [1:0]                 hi_m;
    logic [1:0]                 hi_s;
    logic [1:0]                 lo_m;
    logic [1:0]                 lo_s;
    logic                       mode_m;
    logic                       mode_s;
    logic                       trig_m;
    logic                       trig_s;
    logic [1:0]                 strap_cnt;
    logic                       strap_done;
    logic [6:0]                 slv_addr;
    logic [31:0][7:0]           cfg;
    logic [7:0]                 ptr;
    logic [7:0]                 rdata;
    logic                       loaded;
    logic                       load_err;
    logic                       go;
    logic                       done_oe_n;
    rptr_pkg::ch_cfg_type [7:0] ch_out;
  } bank_state_type;

  bank_state_type q;
  bank_state_type d;

  cfg_load_if lw ();

  ee_loader u_loader (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .lw           (lw.loader),
    .ee_dev_addr  (ee_dev_addr),
    .ee_rd_req    (ee_rd_req),
    .ee_byte_addr (ee_byte_addr),
    .ee_rd_valid  (ee_rd_valid),
    .ee_rd_data   (ee_rd_data),
    .ee_rd_err    (ee_rd_err)
  );

  always_comb begin
    logic [7:0] b_ctrl;
    logic [7:0] b_boost;
    logic [7:0] b_gain;
    logic [7:0] b_taps;
    logic       slave_rst;
    b_ctrl    = 8'h00;
    b_boost   = 8'h00;
    b_gain    = 8'h00;
    b_taps    = 8'h00;
    slave_rst = 1'b0;
    d         = q;

    // Pin synchronisers
    d.sd_m   = sig_detect;
    d.sd_s   = q.sd_m;
    d.hi_m   = strap_hi_lvl;
    d.hi_s   = q.hi_m;
    d.lo_m   = strap_lo_lvl;
    d.lo_s   = q.lo_m;
    d.mode_m = mgmt_mode_select;
    d.mode_s = q.mode_m;
    d.trig_m = load_trigger_n;
    d.trig_s = q.trig_m;

    // Straps are caught once the synchronisers hold post-reset values
    if (!q.strap_done) begin
      if (q.strap_cnt == rptr_pkg::STRAP_SETTLE) begin
        d.strap_done = 1'b1;
        // Each 2-bit code is low, resistor, float, high as 0..3
        d.slv_addr = rptr_pkg::SLV_ADDR_BASE + {3'b000, q.hi_s, 2'b00}
                   + {5'b00000, q.lo_s};
      end else begin
        d.strap_cnt = q.strap_cnt + 2'h1;
      end
    end

    // Read data stands for one cycle only
    d.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr <= rptr_pkg::ADDR_CFG_LAST) begin
        d.rdata = q.cfg[reg_addr[4:0]];
      end else begin
        case (reg_addr)
          rptr_pkg::ADDR_SLV_ADDR: d.rdata = {1'b0, q.slv_addr};
          rptr_pkg::ADDR_STATUS:   d.rdata = {3'b000, q.strap_done,
                                              q.load_err, q.loaded,
                                              lw.busy, q.mode_s};
          rptr_pkg::ADDR_PTR:      d.rdata = q.ptr;
          rptr_pkg::ADDR_DATA: begin
            if (q.ptr <= rptr_pkg::ADDR_CFG_LAST) begin
              d.rdata = q.cfg[q.ptr[4:0]];
            end
          end
          default: d.rdata = 8'h00;
        endcase
      end
    end

    // Loader writes win; register-port writes are ignored while it runs, reads are still served
    if (lw.we) begin
      d.cfg[lw.idx] = lw.data;
    end else if (reg_wr && !lw.busy) begin
      if (reg_addr <= rptr_pkg::ADDR_CFG_LAST) begin
        d.cfg[reg_addr[4:0]] = reg_wdata;
      end else begin
        case (reg_addr)
          rptr_pkg::ADDR_PTR: d.ptr = reg_wdata;
          rptr_pkg::ADDR_DATA: begin
            if (q.ptr <= rptr_pkg::ADDR_CFG_LAST) begin
              d.cfg[q.ptr[4:0]] = reg_wdata;
            end
            d.ptr = q.ptr + 8'h01;
          end
          default: d.ptr = q.ptr;
        endcase
      end
    end

    // Trigger doubles as a register reset only when strapped slave
    slave_rst = q.mode_s && !q.trig_s;
    if (slave_rst) begin
      d.cfg = {rptr_pkg::NUM_CFG{rptr_pkg::CFG_RESET}};
      d.ptr = rptr_pkg::PTR_RESET;
    end

    // Self-load starts only in master mode and only once
    d.go = !q.mode_s && !q.trig_s && !q.loaded && q.strap_done;
    if (lw.done) d.loaded = 1'b1;
    if (lw.err) d.load_err = 1'b1;

    // Done pin: released unless slave trigger is low or a load finished
    d.done_oe_n = 1'b1;
    if (q.mode_s && !q.trig_s) d.done_oe_n = 1'b0;
    if (q.loaded) d.done_oe_n = 1'b0;

    // Each channel reads only its own four bytes
    for (int c = 0; c < rptr_pkg::NUM_CH; c++) begin
      b_ctrl  = q.cfg[c * rptr_pkg::REGS_PER_CH + rptr_pkg::SLOT_CTRL];
      b_boost = q.cfg[c * rptr_pkg::REGS_PER_CH + rptr_pkg::SLOT_BOOST];
      b_gain  = q.cfg[c * rptr_pkg::REGS_PER_CH + rptr_pkg::SLOT_GAIN];
      b_taps  = q.cfg[c * rptr_pkg::REGS_PER_CH + rptr_pkg::SLOT_TAPS];
      d.ch_out[c].boost1  = b_boost[rptr_pkg::BOOST1_LSB +: 3];
      d.ch_out[c].boost2  = b_boost[rptr_pkg::BOOST2_LSB +: 3];
      d.ch_out[c].bypass  = b_ctrl[rptr_pkg::BYPASS_BIT];
      d.ch_out[c].bw      = b_ctrl[rptr_pkg::BW_LSB +: 2];
      d.ch_out[c].gain_hi = b_ctrl[rptr_pkg::GAIN_HI_BIT];
      d.ch_out[c].dc_gain = b_gain[rptr_pkg::DC_GAIN_LSB +: 3];
      d.ch_out[c].limit_en = b_ctrl[rptr_pkg::LIMIT_BIT];
      // Taps only matter in limiting mode; polarity is fixed downstream
      d.ch_out[c].pre  = b_taps[rptr_pkg::PRE_LSB +: 3];
      d.ch_out[c].main = b_gain[rptr_pkg::MAIN_LSB +: 3];
      d.ch_out[c].post = b_taps[rptr_pkg::POST_LSB +: 3];
      case (b_ctrl[rptr_pkg::SD_OVR_LSB +: 2])
        rptr_pkg::SD_FORCE_ON:  d.ch_out[c].path_en = 1'b1;
        rptr_pkg::SD_FORCE_OFF: d.ch_out[c].path_en = 1'b0;
        default:                d.ch_out[c].path_en = q.sd_s[c];
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q           <= '0;
      q.cfg       <= {rptr_pkg::NUM_CFG{rptr_pkg::CFG_RESET}};
      q.ptr       <= rptr_pkg::PTR_RESET;
      q.done_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign lw.go            = q.go;
  assign reg_rdata        = q.rdata;
  assign load_done_n_o    = 1'b0;
  assign load_done_n_oe_n = q.done_oe_n;
  assign ch_cfg           = q.ch_out;
  assign slave_addr       = q.slv_addr;
endmodule
`default_nettype wire

// ### tb/ee_model.sv
// Byte-level EEPROM behind the self-load port.
// Assumes requests are single-cycle pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ee_model (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       err_mode,
  input wire logic [7:0] ee_dev_addr,
  input wire logic       ee_rd_req,
  input wire logic [9:0] ee_byte_addr,
  output logic           ee_rd_valid,
  output logic [7:0]     ee_rd_data,
  output logic           ee_rd_err
);
  logic [9:0] addr_q;
  logic [2:0] wait_q;
  // Odd bytes answer slowly; idle data toggles so it is never stale
  // With err_mode set every answer is a failed read instead
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 3'h0;
      addr_q <= 10'h000;
      ee_rd_valid <= 1'b0;
      ee_rd_err <= 1'b0;
      ee_rd_data <= 8'h00;
    end else begin
      ee_rd_valid <= 1'b0;
      ee_rd_err <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      if (ee_rd_req && ee_dev_addr == 8'hA0) begin
        addr_q <= ee_byte_addr;
        wait_q <= ee_byte_addr[0] ? 3'h3 : 3'h1;
      end else if (wait_q == 3'h1) begin
        wait_q <= 3'h0;
        ee_rd_valid <= !err_mode;
        ee_rd_err <= err_mode;
        ee_rd_data <= 8'(addr_q * 37) ^ 8'h5A;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/repeater_cfg_sva.sv
// Checker for the repeater configuration bank's pins.
// Assumes one clock, sys_clk, and asynchronous active-low resetn.
`timescale 1ns/1ps
`default_nettype none
module repeater_cfg_sva (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic [1:0] strap_hi_lvl,
  input wire logic [1:0] strap_lo_lvl,
  input wire logic       mgmt_mode_select,
  input wire logic       load_trigger_n,
  input wire logic       load_done_n_o,
  input wire logic       load_done_n_oe_n,
  input wire logic [6:0] slave_addr,
  input wire logic [7:0] ee_dev_addr,
  input wire logic       ee_rd_req,
  input wire logic [9:0] ee_byte_addr,
  input wire logic       ee_rd_valid,
  input wire rptr_pkg::ch_cfg_type [7:0] ch_cfg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [9:0] last_q;
  logic       cfg_set;
  // path_en is left out: it follows the detector, not the registers
  always_comb begin
    cfg_set = 1'b0;
    for (int c = 0; c < 8; c++)
      cfg_set = cfg_set | (|ch_cfg[c][23:1]);
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      last_q <= 10'h000;
    else if (ee_rd_req)
      last_q <= ee_byte_addr;
  end
  property p_trig_clr;
    (mgmt_mode_select && !load_trigger_n) [*6] |-> !cfg_set;
  endproperty
  a_trig_clr: assert property (p_trig_clr)
    else $error("config kept under trigger");
  property p_done_low;
    (mgmt_mode_select && !load_trigger_n) [*5] |-> !load_done_n_oe_n;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done pin not driven");
  property p_done_rel;
    (mgmt_mode_select && load_trigger_n) [*5] |-> load_done_n_oe_n;
  endproperty
  a_done_rel: assert property (p_done_rel)
    else $error("done pin not released");
  property p_done_val;
    !load_done_n_oe_n |-> !load_done_n_o;
  endproperty
  a_done_val: assert property (p_done_val)
    else $error("done pin driven high");
  property p_addr_calc;
    $changed(slave_addr) |->
      slave_addr == 7'h18 + {3'h0, strap_hi_lvl, strap_lo_lvl};
  endproperty
  a_addr_calc: assert property (p_addr_calc)
    else $error("slave address wrong");
  property p_addr_hold;
    slave_addr != 7'h00 |=> $stable(slave_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("slave address moved");
  property p_ee_dev;
    ee_rd_req |-> ee_dev_addr == 8'hA0 && !mgmt_mode_select;
  endproperty
  a_ee_dev: assert property (p_ee_dev)
    else $error("eeprom read wrong");
  property p_ee_order;
    ee_rd_req && ee_byte_addr != 10'h000 |-> ee_byte_addr == last_q + 10'h001;
  endproperty
  a_ee_order: assert property (p_ee_order)
    else $error("eeprom byte out of order");
  property p_ee_done;
    ee_rd_valid && ee_byte_addr == 10'h01F && !mgmt_mode_select
      |-> ##[1:6] !load_done_n_oe_n;
  endproperty
  a_ee_done: assert property (p_ee_done)
    else $error("load end not flagged");
  c_slv_rst: cover property (mgmt_mode_select && !load_done_n_oe_n);
  c_load: cover property (ee_rd_req && ee_byte_addr == 10'h01F);
  c_addr: cover property ($changed(slave_addr));
endmodule
`default_nettype wire

// ### tb/repeater_cfg_tb.sv
// Self-checking bench for the repeater configuration bank.
// Assumes ee_model as far side and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module repeater_cfg_tb;
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] sig_detect = 8'hA5;
  logic [1:0] strap_hi_lvl = 2'h0;
  logic [1:0] strap_lo_lvl = 2'h0;
  logic       mgmt_mode_select = 1'b1;
  logic       load_trigger_n = 1'b1;
  logic       err_mode = 1'b0;
  logic       load_done_n_o;
  logic       load_done_n_oe_n;
  logic [6:0] slave_addr;
  logic [7:0] ee_dev_addr;
  logic       ee_rd_req;
  logic [9:0] ee_byte_addr;
  logic       ee_rd_valid;
  logic [7:0] ee_rd_data;
  logic       ee_rd_err;
  logic [7:0] reg_m [32];
  int         mismatches = 0;
  int         total_checks = 0;
  int         n_req = 0;
  rptr_pkg::ch_cfg_type [7:0] ch_cfg;
  // Board pull-up holds the released done pin high
  wire logic done_pin = load_done_n_oe_n ? 1'b1 : load_done_n_o;
  // Rows: address, data, expected path_en; only channel 0 goes limiting
  logic [16:0] rows [8] = '{
    {8'h00, 8'h7D, 1'b1}, {8'h01, 8'h3F, 1'b1}, {8'h08, 8'h02, 1'b0},
    {8'h06, 8'h75, 1'b0}, {8'h0F, 8'h2F, 1'b0}, {8'h1C, 8'h03, 1'b1},
    {8'h1D, 8'h2C, 1'b1}, {8'h12, 8'h01, 1'b0}};
  repeater_cfg uut (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sig_detect, .strap_hi_lvl, .strap_lo_lvl, .mgmt_mode_select,
    .load_trigger_n, .load_done_n_o, .load_done_n_oe_n, .ch_cfg,
    .slave_addr, .ee_dev_addr, .ee_rd_req, .ee_byte_addr, .ee_rd_valid,
    .ee_rd_data, .ee_rd_err);
  ee_model em (.sys_clk, .resetn, .err_mode, .ee_dev_addr, .ee_rd_req,
    .ee_byte_addr, .ee_rd_valid, .ee_rd_data, .ee_rd_err);
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (ee_rd_req === 1'b1) n_req++;
  function automatic rptr_pkg::ch_cfg_type exp_ch(int c);
    rptr_pkg::ch_cfg_type e;
    logic [7:0] k, b, g, t;
    k = reg_m[4*c];
    b = reg_m[4*c+1];
    g = reg_m[4*c+2];
    t = reg_m[4*c+3];
    e = '{b[2:0], b[5:3], k[2], k[5:4], k[3], g[2:0], k[6], t[2:0],
          g[6:4], t[5:3], 1'b0};
    e.path_en = k[1:0] == 2'h1 ? 1'b1 : k[1:0] == 2'h2 ? 1'b0 : sig_detect[c];
    return e;
  endfunction
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic cmp_all();
    for (int c = 0; c < 8; c++)
      chk("ch_cfg", ch_cfg[c], exp_ch(c));
  endtask
  task automatic rst(logic m, logic [1:0] h, logic [1:0] l);
    @(posedge sys_clk);
    resetn <= 1'b0;
    mgmt_mode_select <= m;
    strap_hi_lvl <= h;
    strap_lo_lvl <= l;
    load_trigger_n <= 1'b1;
    foreach (reg_m[i]) reg_m[i] = 8'h00;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    wt(8);
    chk("slave_addr", slave_addr, 7'h18 + {3'h0, h, l});
    rd(8'h20, {1'b0, 7'h18 + {3'h0, h, l}});
    cmp_all();
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    rst(1'b1, 2'h2, 2'h3);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][16:9], rows[i][8:1]);
      reg_m[rows[i][13:9]] = rows[i][8:1];
      wt(2);
      chk("path_en", ch_cfg[rows[i][13:11]].path_en, rows[i][0]);
      cmp_all();
      rd(rows[i][16:9], rows[i][8:1]);
    end
    @(posedge sys_clk);
    sig_detect <= 8'h5A;
    wt(4);
    cmp_all();
    wr(8'h22, 8'h1E);
    wr(8'h23, 8'h11);
    wr(8'h23, 8'h22);
    wr(8'h23, 8'h33);
    wr(8'h20, 8'h00);
    wr(8'h40, 8'h7F);
    reg_m[30] = 8'h11;
    reg_m[31] = 8'h22;
    rd(8'h22, 8'h21);
    rd(8'h1F, 8'h22);
    rd(8'h20, 8'h23);
    rd(8'h40, 8'h00);
    rd(8'h21, 8'h11);
    wr(8'h22, 8'h1E);
    rd(8'h23, 8'h11);
    rd(8'h22, 8'h1E);
    cmp_all();
    @(posedge sys_clk);
    strap_hi_lvl <= 2'h0;
    wt(6);
    chk("slave_addr", slave_addr, 7'h23);
    @(posedge sys_clk);
    load_trigger_n <= 1'b0;
    wt(6);
    chk("done_pin", done_pin, 1'b0);
    wr(8'h01, 8'h3F);
    wt(2);
    foreach (reg_m[i]) reg_m[i] = 8'h00;
    cmp_all();
    @(posedge sys_clk);
    load_trigger_n <= 1'b1;
    wt(6);
    chk("done_pin", done_pin, 1'b1);
    rd(8'h01, 8'h00);
    rst(1'b1, 2'h1, 2'h0);
    rst(1'b1, 2'h0, 2'h2);
    rst(1'b0, 2'h3, 2'h1);
    n_req = 0;
    wt(20);
    chk("ee_req", 24'(n_req), 24'h000000);
    @(posedge sys_clk);
    load_trigger_n <= 1'b0;
    for (int i = 0; i < 2000 && done_pin !== 1'b0; i++) wt(1);
    chk("ee_req", 24'(n_req), 24'h000020);
    chk("done_pin", done_pin, 1'b0);
    chk("ee_dev", ee_dev_addr, 8'hA0);
    rd(8'h21, 8'h14);
    foreach (reg_m[i]) reg_m[i] = 8'(i * 37) ^ 8'h5A;
    cmp_all();
    wr(8'h04, 8'h7D);
    reg_m[4] = 8'h7D;
    wt(2);
    cmp_all();
    rst(1'b0, 2'h3, 2'h1);
    @(posedge sys_clk);
    err_mode <= 1'b1;
    load_trigger_n <= 1'b0;
    n_req = 0;
    wt(20);
    chk("ee_req", 24'(n_req), 24'h000001);
    chk("done_pin", done_pin, 1'b1);
    rd(8'h21, 8'h18);
    end_sim();
  end
endmodule
bind repeater_cfg repeater_cfg_sva sva_i (.sys_clk, .resetn, .strap_hi_lvl,
  .strap_lo_lvl, .mgmt_mode_select, .load_trigger_n, .load_done_n_o,
  .load_done_n_oe_n, .slave_addr, .ee_dev_addr, .ee_rd_req, .ee_byte_addr,
  .ee_rd_valid, .ch_cfg);
`default_nettype wire
